// file: bench/pmsc_adc_model.sv
/* Converter front end: one result per enabled channel per start pulse.
   Assumes the bench supplies the raw code and a slow flag. */
`timescale 1ns/1ps
module pmsc_adc_model (
  input wire logic aclk,
  input wire logic adc_start,
  input wire logic [3:0] adc_chan_en,
  input wire logic slow,
  input wire logic [16:0] code,
  output logic adc_valid,
  output logic [1:0] adc_chan,
  output logic adc_last,
  output logic [16:0] adc_bus_raw,
  output logic [16:0] adc_shunt_raw
);
  logic [3:0] en;
  // Idle lines carry the inverse code so stale data never looks valid
  initial begin
    {adc_valid, adc_chan, adc_last, en} = '0;
    {adc_bus_raw, adc_shunt_raw} = {~code, ~code};
    forever begin
      @(posedge aclk);
      if (adc_start) begin
        en = adc_chan_en;
        for (int c = 0; c < 4; c++) begin
          if (en[c]) begin
            repeat (slow ? 5 : 1) @(posedge aclk);
            {adc_valid, adc_chan, adc_last} <= {1'b1, 2'(c), (en >> (c + 1)) == 4'h0};
            {adc_bus_raw, adc_shunt_raw} <= {code, code};
            @(posedge aclk);
            adc_valid <= 1'b0;
            {adc_bus_raw, adc_shunt_raw} <= {~code, ~code};
          end
        end
      end
    end
  end
endmodule

// file: bench/pmsc_chk_assertions.sv
/* Port checker for the snapshot block.
   Assumes a bind into pmsc_top. */
`timescale 1ns/1ps
module pmsc_chk
  import pmsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic power_down_n,
  input wire logic flag_out_one_o,
  input wire logic adc_start,
  input wire logic settle_busy
);
  // Single domain, so one clock and one disable
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_pd; !power_down_n [*4]; endsequence
  property p_b_lat; s_wr |-> ##[1:3] s_axi_bvalid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_refuse; s_wr ##1 settle_busy |-> ##[0:2] (s_axi_bvalid && s_axi_bresp == RESP_SLVERR); endproperty
  a_refuse: assert property (p_refuse) else $error("write in window taken");
  property p_settle; $rose(settle_busy) |-> settle_busy [*8]; endproperty
  a_settle: assert property (p_settle) else $error("window too short");
  property p_start; adc_start |=> !adc_start; endproperty
  a_start: assert property (p_start) else $error("start not a pulse");
  property p_flag; !flag_out_one_o; endproperty
  a_flag: assert property (p_flag) else $error("flag drives high");
  property p_pd; s_pd |-> !s_axi_awready && !settle_busy; endproperty
  a_pd: assert property (p_pd) else $error("alive in power-down");
endmodule

// file: bench/tb_power_monitor_snapshot_control.sv
/* Self-checking bench for pmsc_top with shortened counts.
   Assumes the converter model and checker are compiled first. */
`timescale 1ns/1ps
module tb_power_monitor_snapshot_control;
  import pmsc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} pmsc_row_t;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, power_down_n = 1, rate_pin_i = 0, slow = 0, s_axi_awready, s_axi_wready;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, c1, c2, c3;
  logic [3:0] s_axi_wstrb = 4'hF, adc_chan_en;
  logic [1:0] s_axi_bresp, s_axi_rresp, adc_chan;
  logic [16:0] code = 17'h04000, adc_bus_raw, adc_shunt_raw;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, flag_out_one_o, flag_out_one_oe, adc_start, adc_valid;
  logic adc_last, sleep_state, settle_busy;
  int fail_count = 0, comparisons = 0, cyc = 0;
  // Reset values of ctrl, format, rate cfg, status, count, bus0, unmapped
  pmsc_row_t rows[7] = '{'{8'h04, 0, RESP_OKAY}, '{8'h74, 0, RESP_OKAY}, '{8'h7C, 6, RESP_OKAY},
    '{8'h70, 1, RESP_OKAY}, '{8'h08, 0, RESP_OKAY}, '{8'h0C, 0, RESP_OKAY}, '{8'h80, 0, RESP_SLVERR}};
  pmsc_top #(.SETTLE_CYCLES(50), .CHAN_CYCLES(10), .PWRUP_CYCLES(20), .PER_A(40), .PER_B(80),
    .PER_C(160), .PER_D(320)) i_dut (.*);
  pmsc_adc_model i_adc (.*);
  always #4 aclk = ~aclk;
  task automatic final_report();
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Bus master: request held until its ready edge, response ready held until answered
  task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] er);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, wd, 3'h7};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] rdv, input logic [1:0] er);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    rdv = s_axi_rdata;
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  // Snapshot, then wait out the window plus a few conversions
  task automatic snap(input logic [7:0] a);
    while (settle_busy) @(posedge aclk);
    wr(a, 0, RESP_OKAY);
    do @(posedge aclk); while (settle_busy);
    repeat (200) @(posedge aclk);
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    repeat (60) @(posedge aclk);
    foreach (rows[i]) begin
      rd(rows[i].a, d, rows[i].r);
      chk(d, rows[i].d);
    end
    wr(8'h74, 1, RESP_OKAY);
    wr(8'h78, 0, RESP_OKAY);
    wr(8'h74, 0, RESP_SLVERR);
    snap(8'h00);
    rd(8'h0C, d, RESP_OKAY);
    chk(d, 32'h2000);
    // Hold keeps counting, reset clears after capture
    slow <= 1;
    code <= 17'h1C000;
    snap(8'h78);
    rd(8'h08, c1, RESP_OKAY);
    snap(8'h78);
    rd(8'h08, c2, RESP_OKAY);
    chk(32'(c2 > c1), 1);
    snap(8'h00);
    rd(8'h08, c3, RESP_OKAY);
    snap(8'h78);
    rd(8'h08, d, RESP_OKAY);
    chk(32'(d < c3), 1);
    wr(8'h04, 32'(MODE_SLEEP), RESP_OKAY);
    snap(8'h78);
    chk(32'(sleep_state), 1);
    wr(8'h04, 0, RESP_OKAY);
    snap(8'h78);
    chk(32'(sleep_state), 0);
    rd(8'h0C, d, RESP_OKAY);
    chk(d, 32'hE000);
    rd(8'h1C, d, RESP_OKAY);
    chk(d, 0);
    // Pin level and edge records, edge snapshots off by default
    rate_pin_i <= 1;
    repeat (8) @(posedge aclk);
    rd(8'h7C, d, RESP_OKAY);
    chk(d, 32'h1E);
    rate_pin_i <= 0;
    repeat (8) @(posedge aclk);
    rd(8'h7C, d, RESP_OKAY);
    chk(d, 32'h36);
    wr(8'h70, 1, RESP_OKAY);
    rd(8'h70, d, RESP_OKAY);
    chk(d, 0);
    wr(8'h04, 32'(MODE_64), RESP_OKAY);
    s_axi_wstrb <= 4'h2;
    wr(8'h04, 32'h305, RESP_OKAY);
    rd(8'h04, d, RESP_OKAY);
    chk(d, 32'h302);
    power_down_n <= 0;
    repeat (10) @(posedge aclk);
    power_down_n <= 1;
    repeat (10) @(posedge aclk);
    rd(8'h04, d, RESP_OKAY);
    chk(d, 0);
    rd(8'h70, d, RESP_OKAY);
    chk(d, 1);
    final_report();
  end
endmodule
bind pmsc_top pmsc_chk i_chk (.*);

// file: hw/pmsc_pkg.sv
/*
  Shared constants for the power monitor snapshot control block: timing,
  sample rates, register indices, field positions and reset values.
  Assumes a single 125 MHz system clock; byte address = 4 x register index.
*/
package pmsc_pkg;

  // Clock and timing
  localparam int CLK_HZ = 125_000_000;
  localparam int T_SETTLE_US = 1000;
  localparam int T_CHAN_US = 200;
  localparam int T_PWRUP_US = 1000;
  localparam int SETTLE_CYC = (CLK_HZ / 1_000_000) * T_SETTLE_US;
  localparam int CHAN_CYC = (CLK_HZ / 1_000_000) * T_CHAN_US;
  localparam int PWRUP_CYC = (CLK_HZ / 1_000_000) * T_PWRUP_US;

  // Sample rates in samples per second and their periods in cycles
  localparam int SPS_1024 = 1024;
  localparam int SPS_256 = 256;
  localparam int SPS_64 = 64;
  localparam int SPS_8 = 8;
  localparam int PER_1024 = CLK_HZ / SPS_1024;
  localparam int PER_256 = CLK_HZ / SPS_256;
  localparam int PER_64 = CLK_HZ / SPS_64;
  localparam int PER_8 = CLK_HZ / SPS_8;
  localparam int CNT_W = 24;

  localparam int NUM_CH = 4;

  // Sample mode field encodings
  localparam logic [2:0] MODE_1024 = 3'h0;
  localparam logic [2:0] MODE_256 = 3'h1;
  localparam logic [2:0] MODE_64 = 3'h2;
  localparam logic [2:0] MODE_8 = 3'h3;
  localparam logic [2:0] MODE_SINGLE = 3'h4;
  localparam logic [2:0] MODE_BURST = 3'h5;
  localparam logic [2:0] MODE_FAST = 3'h6;
  localparam logic [2:0] MODE_SLEEP = 3'h7;

  // Register indices
  localparam logic [5:0] IDX_RESET_CMD = 6'h00;
  localparam logic [5:0] IDX_CTRL = 6'h01;
  localparam logic [5:0] IDX_COUNT = 6'h02;
  localparam logic [5:0] IDX_BUS0 = 6'h03;
  localparam logic [5:0] IDX_SHUNT0 = 6'h07;
  localparam logic [5:0] IDX_PWR0 = 6'h0B;
  localparam logic [5:0] IDX_ACC0 = 6'h0F;
  localparam logic [5:0] IDX_STATUS = 6'h1C;
  localparam logic [5:0] IDX_FORMAT = 6'h1D;
  localparam logic [5:0] IDX_HOLD_CMD = 6'h1E;
  localparam logic [5:0] IDX_RATECFG = 6'h1F;

  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DIS_LSB = 4;
  localparam int CTRL_FLAG_SEL = 8;
  localparam int CTRL_FLAG_DRV = 9;
  // Format fields: bus bipolar, shunt bipolar, bus half, shunt half
  localparam int FMT_BUS_BIP_LSB = 0;
  localparam int FMT_SH_BIP_LSB = 4;
  localparam int FMT_BUS_HALF_LSB = 8;
  localparam int FMT_SH_HALF_LSB = 12;
  // Status fields
  localparam int ST_POR = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_SLEEP = 2;
  // Rate pin config fields
  localparam int RC_HOLD = 0;
  localparam int RC_DIS_RISE = 1;
  localparam int RC_DIS_FALL = 2;
  localparam int RC_LEVEL = 3;
  localparam int RC_ROSE = 4;
  localparam int RC_FELL = 5;

  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] FMT_RST = 16'h0000;
  localparam logic [2:0] RATECFG_RST = 3'h6;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CY_WAIT, CY_PWRUP, CY_CONV} pmsc_cycle_t;

endpackage

// file: hw/pmsc_top.sv
/*
  Snapshot control and result formatting for a four-channel power monitor,
  with an AXI4-Lite register slave, power-down and rate-reduce pins.
  Assumes an ADC front end on aclk that takes one start pulse per cycle and
  returns 17-bit signed raw results per channel, flagging the last one.
*/
// Operation
// - Hold snapshot copies latest bus, shunt, power, accumulator, count; host waits 1 ms.
// - Burst or fast with channels off: settle 200 us per channel, plus one in fast.
// - Conversion keeps running during snapshots; snapshot registers hold until next snapshot.
// - Hold snapshot leaves accumulator and count untouched.
// - Reset snapshot captures then clears accumulator and count; sampling continues.
// - Hold snapshot also applies pending control changes, like the reset snapshot.
// - Sleep between cycles when rate below 1024 SPS or under four channels.
// - Sleep is entered by mode write plus snapshot; left by mode write plus snapshot.
// - Single-shot idle also causes sleep; bus keeps working while asleep.
// - Power-down pin low clears everything; release restarts with default settings.
// - Power-on flag set on every reset; software clears and polls it.
// - Rate pin high forces 8 SPS from the next conversion cycle on.
// - Pin assigned to flag output no longer controls rate; 8 SPS stays programmable.
// - Single-shot: pin rise starts sampling after 1 ms; in sleep it starts nothing.
// - Enabled pin edges do a limited snapshot without applying pending control.
// - Rate pin config selects type, disables edges, shows level, records edges.
// - Bus result is 16 bits; its top 14 bits times shunt form the power product.
// - Bus result unsigned by default; two's complement when bipolar.
// - Shunt result unsigned by default; two's complement when bidirectional.
// - Half range per channel for bus and shunt; bipolar keeps 16-bit resolution.
// - Unipolar, full or half, weighs range/2^16 per LSB; bipolar, full or half, range/2^15.
// - Commands within the settling window are ignored and refused on the bus.
// - Default rate 1024 SPS after reset; 256, 64, 8 SPS programmable.
`timescale 1ns/1ps
module pmsc_top
  import pmsc_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int CHAN_CYCLES = CHAN_CYC,
  parameter int PWRUP_CYCLES = PWRUP_CYC,
  parameter int PER_A = PER_1024,
  parameter int PER_B = PER_256,
  parameter int PER_C = PER_64,
  parameter int PER_D = PER_8
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_down_n,
  input wire logic rate_pin_i,
  output logic flag_out_one_o,
  output logic flag_out_one_oe,
  output logic adc_start,
  output logic [NUM_CH-1:0] adc_chan_en,
  input wire logic adc_valid,
  input wire logic [1:0] adc_chan,
  input wire logic adc_last,
  input wire logic [16:0] adc_bus_raw,
  input wire logic [16:0] adc_shunt_raw,
  output logic sleep_state,
  output logic settle_busy
);

  // Raw 17-bit signed code to a 16-bit result word
  function automatic logic [15:0] fmt_code(input logic [16:0] raw, input logic bip, input logic half);
    logic [15:0] r;
    r = 16'h0000;
    if (!bip) begin
      if (raw[16]) r = 16'h0000;
      else if (!half) r = raw[15:0];
      else if (raw[15]) r = 16'hFFFF;
      else r = {raw[14:0], 1'b0};
    end else if (!half) begin
      r = raw[16:1];
    end else if (raw[16] != raw[15]) begin
      r = raw[16] ? 16'h8000 : 16'h7FFF;
    end else begin
      r = raw[15:0];
    end
    return r;
  endfunction

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) r[7:0] = d[7:0];
    if (be[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  function automatic logic [2:0] count_on(input logic [NUM_CH-1:0] dis);
    logic [2:0] n;
    n = 3'h0;
    for (int k = 0; k < NUM_CH; k++) begin
      n = n + {2'b00, ~dis[k]};
    end
    return n;
  endfunction

  logic pd_s1, pd_s2, rp_s1, rp_s2, rp_s3;
  logic rst;
  logic aw_held, w_held;
  logic [5:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, wr_ok, cmd_reset, cmd_hold;
  logic [15:0] ctrl_pend_reg, ctrl_act_reg, fmt_pend_reg, fmt_act_reg;
  logic [2:0] rcfg_reg;
  logic rose_reg, fell_reg, por_reg;
  logic [CNT_W-1:0] settle_reg, per_reg;
  logic snap_go, snap_clear, snap_apply;
  logic pin_rise, pin_fall, pin_rate, pin_snap;
  logic [2:0] mode, n_on;
  logic [NUM_CH-1:0] dis;
  logic flag_sel;
  logic [CNT_W-1:0] settle_len, per_len;
  pmsc_cycle_t cy_reg;
  logic conv_busy_reg, acc_en_reg;
  logic [1:0] acc_ch_reg;
  logic [31:0] cnt_reg, snap_cnt;
  logic [15:0] live_bus [NUM_CH];
  logic [15:0] live_sh [NUM_CH];
  logic [29:0] live_pwr [NUM_CH];
  logic [55:0] acc [NUM_CH];
  logic [15:0] snap_bus [NUM_CH];
  logic [15:0] snap_sh [NUM_CH];
  logic [29:0] snap_pwr [NUM_CH];
  logic [55:0] snap_acc [NUM_CH];
  logic [31:0] rd_word;
  logic rd_ok;

  // Pin synchronisers; power-down sync only sees the bus reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_s1 <= 1'b0;
      pd_s2 <= 1'b0;
    end else begin
      pd_s1 <= power_down_n;
      pd_s2 <= pd_s1;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      rp_s1 <= 1'b0;
      rp_s2 <= 1'b0;
      rp_s3 <= 1'b0;
    end else begin
      rp_s1 <= rate_pin_i;
      rp_s2 <= rp_s1;
      rp_s3 <= rp_s2;
    end
  end

  // Power-down acts as a full reset, bus slave included
  assign rst = !aresetn || !pd_s2;

  assign mode = ctrl_act_reg[CTRL_MODE_LSB +: 3];
  assign dis = ctrl_act_reg[CTRL_DIS_LSB +: NUM_CH];
  assign flag_sel = ctrl_act_reg[CTRL_FLAG_SEL];
  assign n_on = count_on(dis);
  assign pin_rise = rp_s2 && !rp_s3;
  assign pin_fall = !rp_s2 && rp_s3;
  assign pin_rate = rp_s2 && !flag_sel;
  assign pin_snap = !flag_sel && ((pin_rise && !rcfg_reg[RC_DIS_RISE]) || (pin_fall && !rcfg_reg[RC_DIS_FALL]));

  // AXI write channels, taken in either order
  always_ff @(posedge aclk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_idx <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held <= 1'b1;
        aw_idx <= s_axi_awaddr[7:2];
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_held <= 1'b0;
      end
      s_axi_awready <= !aw_held && !(s_axi_awready && s_axi_awvalid) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wready && s_axi_wvalid) && !s_axi_bvalid;
    end
  end

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  // Writes in the settling window are dropped
  assign wr_ok = wr_fire && (settle_reg == '0);
  assign cmd_reset = wr_ok && (aw_idx == IDX_RESET_CMD);
  assign cmd_hold = wr_ok && (aw_idx == IDX_HOLD_CMD);

  // Write response: error for refused or unmapped writes
  always_ff @(posedge aclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (!wr_ok) s_axi_bresp <= RESP_SLVERR;
      else if (aw_idx == IDX_RESET_CMD || aw_idx == IDX_HOLD_CMD || aw_idx == IDX_CTRL ||
               aw_idx == IDX_STATUS || aw_idx == IDX_FORMAT || aw_idx == IDX_RATECFG) begin
        s_axi_bresp <= RESP_OKAY;
      end else s_axi_bresp <= RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Pending control and format words; live only after a full snapshot
  always_ff @(posedge aclk) begin
    if (rst) begin
      ctrl_pend_reg <= CTRL_RST;
      fmt_pend_reg <= FMT_RST;
    end else if (wr_ok) begin
      if (aw_idx == IDX_CTRL) ctrl_pend_reg <= merge16(ctrl_pend_reg, w_data, w_strb);
      if (aw_idx == IDX_FORMAT) fmt_pend_reg <= merge16(fmt_pend_reg, w_data, w_strb);
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      ctrl_act_reg <= CTRL_RST;
      fmt_act_reg <= FMT_RST;
    end else if (snap_apply) begin
      ctrl_act_reg <= ctrl_pend_reg;
      fmt_act_reg <= fmt_pend_reg;
    end
  end

  // Rate pin config and edge records; an edge beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (rst) begin
      rcfg_reg <= RATECFG_RST;
      rose_reg <= 1'b0;
      fell_reg <= 1'b0;
    end else begin
      if (wr_ok && aw_idx == IDX_RATECFG && w_strb[0]) rcfg_reg <= w_data[2:0];
      if (pin_rise) rose_reg <= 1'b1;
      else if (wr_ok && aw_idx == IDX_RATECFG && w_strb[0] && w_data[RC_ROSE]) rose_reg <= 1'b0;
      if (pin_fall) fell_reg <= 1'b1;
      else if (wr_ok && aw_idx == IDX_RATECFG && w_strb[0] && w_data[RC_FELL]) fell_reg <= 1'b0;
    end
  end

  // Power-on flag: set by any reset, write one to clear
  always_ff @(posedge aclk) begin
    if (rst) por_reg <= 1'b1;
    else if (wr_ok && aw_idx == IDX_STATUS && w_strb[0] && w_data[ST_POR]) por_reg <= 1'b0;
  end

  // Snapshot triggers: commands win over a same-cycle pin edge
  assign snap_go = cmd_reset || cmd_hold || pin_snap;
  assign snap_apply = cmd_reset || cmd_hold;
  assign snap_clear = cmd_reset || (!cmd_hold && pin_snap && !rcfg_reg[RC_HOLD]);

  // Settling window length
  always_comb begin
    settle_len = CNT_W'(SETTLE_CYCLES);
    if (snap_apply && (mode == MODE_BURST || mode == MODE_FAST) && n_on < 3'(NUM_CH)) begin
      settle_len = CNT_W'(CHAN_CYCLES * (int'(n_on) + ((mode == MODE_FAST) ? 1 : 0)));
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) settle_reg <= '0;
    else if (snap_go) settle_reg <= settle_len;
    else if (settle_reg != '0) settle_reg <= settle_reg - CNT_W'(1);
  end

  // Period of the next cycle, picked when the cycle starts
  always_comb begin
    unique case (mode)
      MODE_256: per_len = CNT_W'(PER_B);
      MODE_64: per_len = CNT_W'(PER_C);
      MODE_8: per_len = CNT_W'(PER_D);
      MODE_BURST, MODE_FAST: per_len = CNT_W'(1);
      default: per_len = CNT_W'(PER_A);
    endcase
    if (pin_rate && mode != MODE_SINGLE) per_len = CNT_W'(PER_D);
  end

  // Conversion cycle sequencer; snapshots never stop it
  always_ff @(posedge aclk) begin
    if (rst) begin
      cy_reg <= CY_WAIT;
      per_reg <= CNT_W'(PER_A);
      adc_start <= 1'b0;
      adc_chan_en <= '0;
      conv_busy_reg <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      if (adc_valid && adc_last) conv_busy_reg <= 1'b0;
      unique case (cy_reg)
        CY_WAIT: begin
          if (mode == MODE_SLEEP) begin
            per_reg <= CNT_W'(PER_A);
          end else if (mode == MODE_SINGLE) begin
            if (pin_rise && !flag_sel) begin
              cy_reg <= CY_PWRUP;
              per_reg <= CNT_W'(PWRUP_CYCLES);
            end else if (snap_apply && ctrl_pend_reg[CTRL_MODE_LSB +: 3] == MODE_SINGLE) begin
              cy_reg <= CY_CONV;
            end
          end else if (per_reg > CNT_W'(1)) begin
            per_reg <= per_reg - CNT_W'(1);
          end else if (!conv_busy_reg) begin
            cy_reg <= CY_CONV;
          end
        end
        CY_PWRUP: begin
          if (per_reg > CNT_W'(1)) per_reg <= per_reg - CNT_W'(1);
          else cy_reg <= CY_CONV;
        end
        CY_CONV: begin
          adc_start <= 1'b1;
          adc_chan_en <= ~dis;
          conv_busy_reg <= 1'b1;
          per_reg <= per_len;
          cy_reg <= CY_WAIT;
        end
        default: cy_reg <= CY_WAIT;
      endcase
    end
  end

  // Sleep only for slow rate, fewer channels, or sleep/single idle
  always_ff @(posedge aclk) begin
    if (rst) sleep_state <= 1'b0;
    else sleep_state <= !conv_busy_reg && cy_reg == CY_WAIT && !adc_start &&
                        (mode == MODE_SLEEP || mode == MODE_SINGLE || per_len > CNT_W'(PER_A) ||
                         n_on < 3'(NUM_CH));
  end

  // Accumulate one cycle after each result lands
  always_ff @(posedge aclk) begin
    if (rst) begin
      acc_en_reg <= 1'b0;
      acc_ch_reg <= 2'h0;
    end else begin
      acc_en_reg <= adc_valid && !dis[adc_chan];
      acc_ch_reg <= adc_chan;
    end
  end

  // Count of conversion cycles; a reset snapshot restarts it
  always_ff @(posedge aclk) begin
    if (rst) cnt_reg <= 32'h0000_0000;
    else if (snap_clear) cnt_reg <= {31'h0000_0000, adc_valid && adc_last};
    else if (adc_valid && adc_last) cnt_reg <= cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge aclk) begin
    if (rst) snap_cnt <= 32'h0000_0000;
    else if (snap_go) snap_cnt <= cnt_reg;
  end

  // Per-channel live results, accumulators and snapshot copies
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [14:0] bus_x;
    logic [16:0] sh_x;
    logic [31:0] prod;
    logic bus_bip, sh_bip;
    assign bus_bip = fmt_act_reg[FMT_BUS_BIP_LSB + i];
    assign sh_bip = fmt_act_reg[FMT_SH_BIP_LSB + i];
    assign bus_x = {bus_bip & live_bus[i][15], live_bus[i][15:2]};
    assign sh_x = {sh_bip & live_sh[i][15], live_sh[i]};
    assign prod = 32'($signed(bus_x) * $signed(sh_x));

    always_ff @(posedge aclk) begin
      if (rst) begin
        live_bus[i] <= 16'h0000;
        live_sh[i] <= 16'h0000;
        live_pwr[i] <= 30'h0000_0000;
      end else if (adc_valid && adc_chan == 2'(i)) begin
        live_bus[i] <= fmt_code(adc_bus_raw, bus_bip, fmt_act_reg[FMT_BUS_HALF_LSB + i]);
        live_sh[i] <= fmt_code(adc_shunt_raw, sh_bip, fmt_act_reg[FMT_SH_HALF_LSB + i]);
      end else if (acc_en_reg && acc_ch_reg == 2'(i)) begin
        live_pwr[i] <= prod[29:0];
      end
    end

    // Sign-extended power adds in; a reset snapshot keeps only a same-cycle sample
    always_ff @(posedge aclk) begin
      if (rst) acc[i] <= 56'h00_0000_0000_0000;
      else if (snap_clear) acc[i] <= (acc_en_reg && acc_ch_reg == 2'(i)) ? 56'($signed(prod[29:0])) : '0;
      else if (acc_en_reg && acc_ch_reg == 2'(i)) acc[i] <= acc[i] + 56'($signed(prod[29:0]));
    end

    always_ff @(posedge aclk) begin
      if (rst) begin
        snap_bus[i] <= 16'h0000;
        snap_sh[i] <= 16'h0000;
        snap_pwr[i] <= 30'h0000_0000;
        snap_acc[i] <= 56'h00_0000_0000_0000;
      end else if (snap_go) begin
        snap_bus[i] <= live_bus[i];
        snap_sh[i] <= live_sh[i];
        snap_pwr[i] <= live_pwr[i];
        snap_acc[i] <= acc[i];
      end
    end
  end

  // Read decode
  always_comb begin
    logic [5:0] idx;
    idx = s_axi_araddr[7:2];
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (idx >= IDX_BUS0 && idx < IDX_SHUNT0) begin
      rd_word = {16'h0000, snap_bus[2'(idx - IDX_BUS0)]};
    end else if (idx >= IDX_SHUNT0 && idx < IDX_PWR0) begin
      rd_word = {16'h0000, snap_sh[2'(idx - IDX_SHUNT0)]};
    end else if (idx >= IDX_PWR0 && idx < IDX_ACC0) begin
      rd_word = {2'b00, snap_pwr[2'(idx - IDX_PWR0)]};
    end else if (idx >= IDX_ACC0 && idx < IDX_ACC0 + 6'(2 * NUM_CH)) begin
      rd_word = (idx[0] == IDX_ACC0[0]) ? snap_acc[2'((idx - IDX_ACC0) >> 1)][31:0] :
                {8'h00, snap_acc[2'((idx - IDX_ACC0) >> 1)][55:32]};
    end else begin
      unique case (idx)
        IDX_CTRL: rd_word = {16'h0000, ctrl_pend_reg};
        IDX_COUNT: rd_word = snap_cnt;
        IDX_STATUS: rd_word = {29'h0000_0000, sleep_state, settle_reg != '0, por_reg};
        IDX_FORMAT: rd_word = {16'h0000, fmt_pend_reg};
        IDX_RATECFG: rd_word = {26'h000_0000, fell_reg, rose_reg, rp_s2, rcfg_reg};
        IDX_RESET_CMD, IDX_HOLD_CMD: rd_word = 32'h0000_0000;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // Read channel: one answer outstanding
  always_ff @(posedge aclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arready && s_axi_arvalid);
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Open-drain flag output, pulls low only when assigned and driven
  always_ff @(posedge aclk) begin
    if (rst) begin
      flag_out_one_o <= 1'b0;
      flag_out_one_oe <= 1'b0;
      settle_busy <= 1'b0;
    end else begin
      flag_out_one_o <= 1'b0;
      flag_out_one_oe <= flag_sel && ctrl_act_reg[CTRL_FLAG_DRV];
      settle_busy <= snap_go || settle_reg > CNT_W'(1);
    end
  end

endmodule
